// File: include/pmbp_pkg.sv
// shared constants and types for program memory block protection
package pmbp_pkg;
    // memory size variants
    typedef enum logic [1:0] {SZ8K, SZ16K, SZ32K, SZ64K} pmbp_size_e;
    // access source
    typedef enum logic [1:0] {SRC_NONE, SRC_TBLRD, SRC_TBLWT, SRC_EXT} pmbp_src_e;

    localparam logic [21:0] CFG_EXT_BLK = 22'h30_0008;
    localparam logic [21:0] CFG_EXT_BOOT = 22'h30_0009;
    localparam logic [21:0] CFG_WR_BLK = 22'h30_000a;
    localparam logic [21:0] CFG_WR_BOOT = 22'h30_000b;
    localparam logic [21:0] CFG_RD_BLK = 22'h30_000c;
    localparam logic [21:0] CFG_RD_BOOT = 22'h30_000d;
    localparam logic [21:0] DEVID_LO = 22'h3f_fffe;
    localparam logic [21:0] DEVID_HI = 22'h3f_ffff;
    localparam logic [21:0] CFG_BASE = 22'h30_0000;
    localparam logic [21:0] CFG_LAST = 22'h30_000d;

    // boot block ends
    localparam logic [21:0] BOOT_END_SMALL = 22'h00_01ff;
    localparam logic [21:0] BOOT_END_LARGE = 22'h00_07ff;
    // block boundaries per variant: start of block 1 (also 2 and 3 for 32K and 64K) and top; 32K uses B1_16K for block 1
    localparam logic [21:0] B1_8K = 22'h00_1000;
    localparam logic [21:0] TOP_8K = 22'h00_2000;
    localparam logic [21:0] B1_16K = 22'h00_2000;
    localparam logic [21:0] TOP_16K = 22'h00_4000;
    localparam logic [21:0] B2_32K = 22'h00_4000;
    localparam logic [21:0] B3_32K = 22'h00_6000;
    localparam logic [21:0] TOP_32K = 22'h00_8000;
    localparam logic [21:0] B1_64K = 22'h00_4000;
    localparam logic [21:0] B2_64K = 22'h00_8000;
    localparam logic [21:0] B3_64K = 22'h00_c000;
    localparam logic [21:0] TOP_64K = 22'h01_0000;

    // field positions
    localparam int BOOT_BIT = 6;
    localparam int EE_BIT = 7;
    localparam int CFGW_BIT = 5;
    localparam logic [7:0] MASK_BLK4 = 8'h0f;
    localparam logic [7:0] MASK_BLK2 = 8'h03;
    localparam logic [7:0] MASK_BOOTEE = 8'hc0;
    localparam logic [7:0] MASK_WRH = 8'he0;
    localparam logic [7:0] MASK_BOOT = 8'h40;
    localparam logic [7:0] ERASED = 8'hff;

    // region codes: 0..3 blocks, 4 boot, 5 unimplemented, 6 config, 7 other
    localparam logic [2:0] REG_BOOT = 3'h4;
    localparam logic [2:0] REG_NONE = 3'h5;
    localparam logic [2:0] REG_CFG = 3'h6;
    localparam logic [2:0] REG_OTHER = 3'h7;

    typedef struct packed {
        pmbp_src_e src;
        logic wr;
        logic [21:0] addr;
        logic [21:0] fetchPc;
        logic [7:0] wdata;
    } pmbp_req_s;

    typedef struct packed {
        logic valid;
        logic grant;
        logic [7:0] rdata;
        logic flashWr;
    } pmbp_rsp_s;
endpackage

// File: design/pmbp_guard.sv
// access checker for program flash block protection
`timescale 1ns/10ps
`default_nettype none
module pmbp_guard
    import pmbp_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic rst_n, // synchronous reset
    input wire pmbp_size_e memSize, // memory size variant
    input wire logic progMode, // serial programming port active
    input wire pmbp_req_s req, // access request
    input wire logic [7:0] flashRdata, // raw flash/config read data
    input wire logic eraseChip, // chip erase pulse from programmer
    input wire logic eraseBlock, // block erase pulse from programmer
    input wire logic [2:0] eraseSel, // region code to block-erase
    input wire logic eeCpuRd, // cpu eeprom read
    input wire logic eeCpuWr, // cpu eeprom write
    input wire logic eeExtRd, // external eeprom read
    input wire logic eeExtWr, // external eeprom write
    output pmbp_rsp_s rsp, // registered answer
    output logic eeGrant, // eeprom access allowed
    output logic [7:0] extProt, // external protect bits, boot at 4
    output logic [7:0] wrProt, // write protect bits, boot at 4
    output logic [7:0] rdProt // cross read protect bits, boot at 4
);
    logic [7:0] cfgExtBlk;
    logic [7:0] cfgExtBoot;
    logic [7:0] cfgWrBlk;
    logic [7:0] cfgWrBoot;
    logic [7:0] cfgRdBlk;
    logic [7:0] cfgRdBoot;
    logic [7:0] blkMask;
    logic [2:0] tgtRegion;
    logic [2:0] pcRegion;
    logic [4:0] extVec;
    logic [4:0] wrVec;
    logic [4:0] rdVec;
    logic allow;
    logic zeroOut;
    logic cfgWrite;
    logic [7:0] cfgRead;
    logic [7:0] next_rdata;
    logic [7:0] userKeep;

    // map address to region for the selected variant
    function automatic logic [2:0] regionOf(input logic [21:0] a, input pmbp_size_e sz);
        logic [2:0] r;
        r = REG_OTHER;
        if (a >= CFG_BASE)
            r = REG_OTHER;
        else unique case (sz)
            SZ8K:
                r = (a <= BOOT_END_SMALL) ? REG_BOOT : (a < B1_8K) ? 3'h0 :
                    (a < TOP_8K) ? 3'h1 : REG_NONE;
            SZ16K:
                r = (a <= BOOT_END_LARGE) ? REG_BOOT : (a < B1_16K) ? 3'h0 :
                    (a < TOP_16K) ? 3'h1 : REG_NONE;
            SZ32K:
                r = (a <= BOOT_END_LARGE) ? REG_BOOT : (a < B1_16K) ? 3'h0 :
                    (a < B2_32K) ? 3'h1 : (a < B3_32K) ? 3'h2 :
                    (a < TOP_32K) ? 3'h3 : REG_NONE;
            SZ64K:
                r = (a <= BOOT_END_LARGE) ? REG_BOOT : (a < B1_64K) ? 3'h0 :
                    (a < B2_64K) ? 3'h1 : (a < B3_64K) ? 3'h2 :
                    (a < TOP_64K) ? 3'h3 : REG_NONE;
        endcase
        return r;
    endfunction

    // pick one protection bit for a region; boot at index 4
    function automatic logic bitOf(input logic [4:0] v, input logic [2:0] r);
        return (r <= REG_BOOT) ? v[r] : 1'b1;
    endfunction

    assign blkMask = (memSize == SZ32K || memSize == SZ64K) ? MASK_BLK4 : MASK_BLK2;
    assign tgtRegion = regionOf(req.addr, memSize);
    assign pcRegion = regionOf(req.fetchPc, memSize);
    assign extVec = {cfgExtBoot[BOOT_BIT], cfgExtBlk[3:0] | ~blkMask[3:0]};
    assign wrVec = {cfgWrBoot[BOOT_BIT], cfgWrBlk[3:0] | ~blkMask[3:0]};
    assign rdVec = {cfgRdBoot[BOOT_BIT], cfgRdBlk[3:0] | ~blkMask[3:0]};
    // self-programming may never touch the config-write bit; only the port may
    assign userKeep = (req.src == SRC_TBLWT) ? 8'(1 << CFGW_BIT) : 8'h00;

    always_comb
    begin
        unique case (req.addr)
            CFG_EXT_BLK: cfgRead = cfgExtBlk & blkMask;
            CFG_EXT_BOOT: cfgRead = cfgExtBoot & MASK_BOOTEE;
            CFG_WR_BLK: cfgRead = cfgWrBlk & blkMask;
            CFG_WR_BOOT: cfgRead = cfgWrBoot & MASK_WRH;
            CFG_RD_BLK: cfgRead = cfgRdBlk & blkMask;
            CFG_RD_BOOT: cfgRead = cfgRdBoot & MASK_BOOT;
            default: cfgRead = flashRdata;
        endcase
    end

    // decide whether the access may proceed
    always_comb
    begin
        allow = 1'b1;
        zeroOut = 1'b0;
        cfgWrite = 1'b0;
        unique case (req.src)
            SRC_TBLRD:
            begin
                if (tgtRegion == REG_NONE)
                    zeroOut = 1'b1;
                else if (tgtRegion != pcRegion && !bitOf(rdVec, tgtRegion))
                    zeroOut = 1'b1;
            end
            SRC_TBLWT:
            begin
                if (tgtRegion == REG_NONE)
                    allow = 1'b0;
                else if (req.addr >= CFG_BASE && req.addr <= CFG_LAST)
                begin
                    allow = cfgWrBoot[CFGW_BIT];
                    cfgWrite = allow;
                end
                else
                    allow = bitOf(wrVec, tgtRegion);
            end
            SRC_EXT:
            begin
                if (!progMode || tgtRegion == REG_NONE)
                    allow = 1'b0;
                else if (req.addr >= CFG_BASE && req.addr <= CFG_LAST)
                    cfgWrite = req.wr; // programmer may touch all config
                else
                    allow = bitOf(extVec, tgtRegion);
                zeroOut = !allow;
            end
            default: allow = 1'b0;
        endcase
    end

    always_comb
    begin
        next_rdata = zeroOut ? 8'h00 : cfgRead;
    end

    // config storage: writes only clear, erase sets; erase from port only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfgExtBlk <= ERASED;
            cfgExtBoot <= ERASED;
            cfgWrBlk <= ERASED;
            cfgWrBoot <= ERASED;
            cfgRdBlk <= ERASED;
            cfgRdBoot <= ERASED;
        end
        else if (progMode && eraseChip)
        begin
            cfgExtBlk <= ERASED;
            cfgExtBoot <= ERASED;
            cfgWrBlk <= ERASED;
            cfgWrBoot <= ERASED;
            cfgRdBlk <= ERASED;
            cfgRdBoot <= ERASED;
        end
        else if (progMode && eraseBlock)
        begin
            if (eraseSel == REG_BOOT)
            begin
                cfgExtBoot[BOOT_BIT] <= 1'b1;
                cfgWrBoot[BOOT_BIT] <= 1'b1;
                cfgRdBoot[BOOT_BIT] <= 1'b1;
            end
            else if (eraseSel < REG_BOOT)
            begin
                cfgExtBlk[eraseSel[1:0]] <= 1'b1;
                cfgWrBlk[eraseSel[1:0]] <= 1'b1;
                cfgRdBlk[eraseSel[1:0]] <= 1'b1;
            end
        end
        else if (cfgWrite && req.wr)
        begin
            unique case (req.addr)
                CFG_EXT_BLK: cfgExtBlk <= cfgExtBlk & req.wdata;
                CFG_EXT_BOOT: cfgExtBoot <= cfgExtBoot & req.wdata;
                CFG_WR_BLK: cfgWrBlk <= cfgWrBlk & req.wdata;
                CFG_WR_BOOT: cfgWrBoot <= cfgWrBoot & (req.wdata | userKeep);
                CFG_RD_BLK: cfgRdBlk <= cfgRdBlk & req.wdata;
                CFG_RD_BOOT: cfgRdBoot <= cfgRdBoot & req.wdata;
                default: cfgRdBoot <= cfgRdBoot;
            endcase
        end
    end

    // registered answer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp.valid <= (req.src != SRC_NONE);
            rsp.grant <= (req.src != SRC_NONE) && allow;
            rsp.rdata <= (req.src != SRC_NONE && !req.wr) ? next_rdata : 8'h00;
            rsp.flashWr <= (req.src != SRC_NONE) && req.wr && allow && !cfgWrite &&
                           req.addr < CFG_BASE;
        end
    end

    // eeprom gating and status outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            eeGrant <= 1'b0;
            extProt <= '0;
            wrProt <= '0;
            rdProt <= '0;
        end
        else
        begin
            eeGrant <= eeCpuRd
                || (eeCpuWr && cfgWrBoot[EE_BIT])
                || (eeExtRd && progMode && cfgExtBoot[EE_BIT])
                || (eeExtWr && progMode && cfgExtBoot[EE_BIT] && cfgWrBoot[EE_BIT]);
            extProt <= {3'h0, extVec};
            wrProt <= {3'h0, wrVec};
            rdProt <= {3'h0, rdVec};
        end
    end

    chk_write_block_refused: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_TBLWT && tgtRegion <= REG_BOOT && !bitOf(wrVec, tgtRegion))
        |=> !rsp.grant && !rsp.flashWr)
        else $error("table write into protected block granted");
    chk_foreign_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_TBLRD && tgtRegion <= REG_BOOT && tgtRegion != pcRegion
         && !bitOf(rdVec, tgtRegion)) |=> rsp.rdata == 8'h00)
        else $error("foreign table read returned data");
    chk_same_block_read: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_TBLRD && !req.wr && tgtRegion <= REG_BOOT && tgtRegion == pcRegion)
        |=> rsp.rdata == $past(flashRdata))
        else $error("same block table read lost data");
    chk_bits_no_set: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(eraseChip && progMode) && !$past(eraseBlock && progMode)
        |-> (cfgWrBlk & ~$past(cfgWrBlk)) == 8'h00)
        else $error("protection bit set without erase");
    chk_cfg_user_ro: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_TBLWT && !(progMode && (eraseChip || eraseBlock)))
        |=> $stable(cfgWrBoot[CFGW_BIT]))
        else $error("config protect changed by table write");
    chk_ext_blocked: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_EXT && tgtRegion <= REG_BOOT && !bitOf(extVec, tgtRegion))
        |=> !rsp.grant ##0 rsp.rdata == 8'h00)
        else $error("external access to protected block granted");
    chk_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_TBLRD && tgtRegion == REG_NONE) |=> rsp.rdata == 8'h00)
        else $error("unimplemented space read nonzero");
    chk_eeprom_write: assert property (@(posedge clk) disable iff (!rst_n)
        (!cfgWrBoot[EE_BIT] && !eeCpuRd && !eeExtRd) |=> !eeGrant)
        else $error("eeprom write granted while protected");
    chk_absent_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_TBLRD && req.addr == CFG_RD_BLK && memSize == SZ8K)
        |=> rsp.rdata[3:2] == 2'b00)
        else $error("absent block bits read nonzero");
    chk_unimpl_write: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_TBLWT && tgtRegion == REG_NONE) |=> !rsp.grant && !rsp.flashWr)
        else $error("write to unimplemented space granted");
    chk_ext_needs_port: assert property (@(posedge clk) disable iff (!rst_n)
        (req.src == SRC_EXT && !progMode) |=> !rsp.grant && rsp.rdata == 8'h00)
        else $error("external access granted outside programming mode");
    chk_ee_cpu_read: assert property (@(posedge clk) disable iff (!rst_n)
        eeCpuRd |=> eeGrant)
        else $error("cpu eeprom read refused");
    // no erase is honoured while the port is idle, so no bit may rise then
    chk_erase_port_only: assert property (@(posedge clk) disable iff (!rst_n)
        !progMode |=> ((cfgExtBlk & ~$past(cfgExtBlk)) | (cfgWrBlk & ~$past(cfgWrBlk))
            | (cfgRdBlk & ~$past(cfgRdBlk)) | (cfgExtBoot & ~$past(cfgExtBoot))
            | (cfgWrBoot & ~$past(cfgWrBoot)) | (cfgRdBoot & ~$past(cfgRdBoot))) == 8'h00)
        else $error("protection bit set outside programming mode");
endmodule
`default_nettype wire

// File: testbench/pmbp_flash_model.sv
// program array stand-in that feeds raw read data to the guard
`timescale 1ns/10ps
`default_nettype none
module pmbp_flash_model
    import pmbp_pkg::*;
(
    input wire pmbp_req_s req, // request seen by the guard
    output logic [7:0] flashRdata // raw array data
);
    // contents are a pattern of the address, so no storage is kept
    always_comb flashRdata = req.addr[7:0] ^ req.addr[15:8] ^ 8'h5a;
endmodule
`default_nettype wire

// File: testbench/program_memory_block_protection_tb.sv
// self-checking bench for the program flash block protection guard
`timescale 1ns/10ps
`default_nettype none
module program_memory_block_protection_tb;
    import pmbp_pkg::*;
    typedef struct packed {logic isRd; logic grant; logic [7:0] rdata; logic flashWr;} pmbp_exp_s;
    logic clk = 0, rst_n = 0, progMode = 0, eraseChip = 0, eraseBlock = 0;
    logic eeCpuRd = 0, eeCpuWr = 0, eeExtRd = 0, eeExtWr = 0;
    logic [2:0] eraseSel = 3'h0;
    pmbp_size_e memSize = SZ8K;
    pmbp_req_s req = '0;
    pmbp_rsp_s rsp;
    logic eeGrant;
    logic [7:0] flashRdata, extProt, wrProt, rdProt;
    pmbp_exp_s expQ[$];
    pmbp_exp_s ex;
    int miscompares = 0, checksDone = 0, cycles = 0, seed = 24;
    logic [21:0] topA[4] = '{22'h00_2000, 22'h00_4000, 22'h00_8000, 22'h01_0000};
    logic [21:0] b0A[4] = '{22'h00_0200, 22'h00_0800, 22'h00_0800, 22'h00_0800};
    logic [21:0] a;
    logic [7:0] wd;
    pmbp_guard DUT (.clk(clk), .rst_n(rst_n), .memSize(memSize), .progMode(progMode), .req(req),
        .flashRdata(flashRdata), .eraseChip(eraseChip), .eraseBlock(eraseBlock),
        .eraseSel(eraseSel), .eeCpuRd(eeCpuRd), .eeCpuWr(eeCpuWr), .eeExtRd(eeExtRd),
        .eeExtWr(eeExtWr), .rsp(rsp), .eeGrant(eeGrant), .extProt(extProt), .wrProt(wrProt),
        .rdProt(rdProt));
    pmbp_flash_model partner (.req(req), .flashRdata(flashRdata));
    always #25 clk = ~clk;
    function automatic logic [7:0] pat(input logic [21:0] ad);
        return ad[7:0] ^ ad[15:8] ^ 8'h5a;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] expv, input string what);
        checksDone++;
        if (seen !== expv)
        begin
            miscompares++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, expv);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // a write expects flashWr only when granted into the array
    task automatic acc(input pmbp_src_e s, input logic w, input logic [21:0] ad,
                       input logic [21:0] pc, input logic [7:0] d, input logic g,
                       input logic [7:0] rd);
        @(posedge clk);
        req <= '{src: s, wr: w, addr: ad, fetchPc: pc, wdata: d};
        expQ.push_back('{isRd: !w, grant: g, rdata: rd, flashWr: g && w && ad < CFG_BASE});
    endtask
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk);
            req.src <= SRC_NONE;
        end
    endtask
    task automatic protChk(input logic [7:0] e, input logic [7:0] w, input logic [7:0] r);
        idle(2);
        @(negedge clk);
        check(extProt, e, "external protect");
        check(wrProt, w, "write protect");
        check(rdProt, r, "cross read protect");
    endtask
    task automatic eeChk(input logic [3:0] v, input logic g);
        @(posedge clk);
        {eeCpuRd, eeCpuWr, eeExtRd, eeExtWr} <= v;
        @(posedge clk);
        {eeCpuRd, eeCpuWr, eeExtRd, eeExtWr} <= 4'h0;
        @(negedge clk);
        check({7'h0, eeGrant}, {7'h0, g}, "eeprom grant");
    endtask
    task automatic pulse(input logic chip, input logic [2:0] sel);
        @(posedge clk);
        eraseChip <= chip;
        eraseBlock <= !chip;
        eraseSel <= sel;
        @(posedge clk);
        eraseChip <= 1'b0;
        eraseBlock <= 1'b0;
    endtask
    task automatic doReset(input pmbp_size_e sz);
        idle(1);
        rst_n <= 1'b0;
        memSize <= sz;
        progMode <= 1'b0;
        repeat (12) @(posedge clk);
        expQ.delete();
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    always @(negedge clk)
    begin
        if (rst_n && rsp.valid === 1'b1)
        begin
            if (expQ.size() == 0)
                check(8'h01, 8'h00, "answer without request");
            else
            begin
                ex = expQ.pop_front();
                check({7'h0, rsp.grant}, {7'h0, ex.grant}, "grant");
                if (ex.isRd)
                    check(rsp.rdata, ex.rdata, "read data");
                else
                    check({7'h0, rsp.flashWr}, {7'h0, ex.flashWr}, "array write");
            end
        end
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            $display("mismatch at %0t: run timed out", $time);
            wrap_up();
        end
    end
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            doReset(pmbp_size_e'(i));
            protChk(8'h1f, 8'h1f, 8'h1f);
            acc(SRC_TBLRD, 0, topA[i] - 1, 22'h0, 8'h00, 1, pat(topA[i] - 1));
            acc(SRC_TBLRD, 0, topA[i], 22'h0, 8'h00, 1, 8'h00);
            acc(SRC_TBLWT, 1, CFG_RD_BOOT, 22'h0, 8'hbf, 1, 8'h00);
            acc(SRC_TBLRD, 0, CFG_RD_BOOT, 22'h0, 8'h00, 1, 8'h00);
            acc(SRC_TBLRD, 0, CFG_RD_BLK, 22'h0, 8'h00, 1, (i < 2) ? 8'h03 : 8'h0f);
            idle(2);
            acc(SRC_TBLRD, 0, b0A[i] - 1, b0A[i], 8'h00, 1, 8'h00);
            acc(SRC_TBLRD, 0, b0A[i] - 1, 22'h0, 8'h00, 1, pat(b0A[i] - 1));
            acc(SRC_TBLRD, 0, b0A[i], b0A[i] - 1, 8'h00, 1, pat(b0A[i]));
            idle(2);
            $display("region map test done for size %0d", i);
        end
        doReset(SZ32K);
        a = 22'h00_0800 + 22'($unsigned($random(seed)) % 32'h1800);
        wd = 8'($random(seed));
        acc(SRC_TBLWT, 1, a, 22'h0, wd, 1, 8'h00);
        acc(SRC_TBLRD, 0, DEVID_LO, 22'h0, 8'h00, 1, pat(DEVID_LO));
        acc(SRC_TBLWT, 1, CFG_RD_BLK, 22'h0, 8'hfe, 1, 8'h00);
        protChk(8'h1f, 8'h1f, 8'h1e);
        acc(SRC_TBLRD, 0, a, 22'h0, 8'h00, 1, 8'h00);
        acc(SRC_TBLRD, 0, a, 22'h00_0800, 8'h00, 1, pat(a));
        acc(SRC_TBLWT, 1, CFG_RD_BLK, 22'h0, 8'hff, 1, 8'h00);
        protChk(8'h1f, 8'h1f, 8'h1e);
        acc(SRC_TBLWT, 1, CFG_WR_BLK, 22'h0, 8'hfd, 1, 8'h00);
        idle(2);
        acc(SRC_TBLWT, 1, 22'h00_2000, 22'h0, wd, 0, 8'h00);
        acc(SRC_TBLWT, 1, 22'h00_1fff, 22'h0, wd, 1, 8'h00);
        acc(SRC_TBLWT, 1, 22'h00_8000, 22'h0, wd, 0, 8'h00);
        acc(SRC_EXT, 0, a, 22'h0, 8'h00, 0, 8'h00);
        idle(1);
        progMode <= 1'b1;
        acc(SRC_EXT, 0, a, 22'h0, 8'h00, 1, pat(a));
        acc(SRC_TBLWT, 1, CFG_EXT_BLK, 22'h0, 8'hfe, 1, 8'h00);
        idle(2);
        acc(SRC_EXT, 0, a, 22'h0, 8'h00, 0, 8'h00);
        acc(SRC_TBLRD, 0, a, 22'h00_0800, 8'h00, 1, pat(a));
        idle(2);
        $display("block protection test done");
        eeChk(4'h2, 1);
        eeChk(4'h4, 1);
        eeChk(4'h1, 1);
        acc(SRC_TBLWT, 1, CFG_EXT_BOOT, 22'h0, 8'h7f, 1, 8'h00);
        acc(SRC_TBLWT, 1, CFG_WR_BOOT, 22'h0, 8'h7f, 1, 8'h00);
        idle(2);
        eeChk(4'h2, 0);
        eeChk(4'h8, 1);
        eeChk(4'h4, 0);
        eeChk(4'h1, 0);
        acc(SRC_TBLWT, 1, CFG_WR_BOOT, 22'h0, 8'hdf, 1, 8'h00);
        acc(SRC_TBLRD, 0, CFG_WR_BOOT, 22'h0, 8'h00, 1, 8'h60);
        acc(SRC_EXT, 1, CFG_WR_BOOT, 22'h0, 8'hdf, 1, 8'h00);
        acc(SRC_TBLRD, 0, CFG_WR_BOOT, 22'h0, 8'h00, 1, 8'h40);
        idle(2);
        acc(SRC_TBLWT, 1, CFG_WR_BLK, 22'h0, 8'hfb, 0, 8'h00);
        protChk(8'h1e, 8'h1d, 8'h1e);
        $display("eeprom and config test done");
        @(posedge clk);
        progMode <= 1'b0;
        pulse(1, 3'h0);
        protChk(8'h1e, 8'h1d, 8'h1e);
        @(posedge clk);
        progMode <= 1'b1;
        pulse(0, 3'h0);
        protChk(8'h1f, 8'h1d, 8'h1f);
        pulse(1, 3'h0);
        protChk(8'h1f, 8'h1f, 8'h1f);
        $display("erase test done");
        check(8'(expQ.size()), 8'h00, "answers missing");
        wrap_up();
    end
endmodule
`default_nettype wire
